// ### logic/pfs_pkg.sv
// port function select: shared constants for the pin multiplexer
// assumes eight ports of eight bit slots each, one register triple a port
package pfs_pkg;

	// ****************************************************************
	// sizes and register map
	// ****************************************************************
	localparam int NPORT  = 8;
	localparam int PW     = 8;
	localparam int NPIN   = NPORT * PW;
	localparam int ADDR_W = 5;
	// register slot inside a port's group of four bytes
	localparam logic [1:0] OFS_DATA = 2'h0;
	localparam logic [1:0] OFS_DIR  = 2'h1;
	localparam logic [1:0] OFS_FUNC = 2'h2;

	// ****************************************************************
	// per-port pin capabilities, index order: 1 2 5 6 7 8 9 Z
	// ****************************************************************
	localparam int PORT_P1 = 0;
	localparam int PORT_P2 = 1;
	localparam int PORT_P5 = 2;
	localparam int PORT_PZ = 7;
	// bits with a direction bit
	localparam logic [7:0] CR_MASK [NPORT] = '{
		8'hFF, 8'h00, 8'h78, 8'h00, 8'h3F, 8'hFF, 8'h79, 8'h0C};
	// bits that are output only
	localparam logic [7:0] FIX_MASK [NPORT] = '{
		8'h00, 8'hFF, 8'h00, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h00};
	// bits with a function select bit
	localparam logic [7:0] FC_MASK [NPORT] = '{
		8'hFF, 8'hFF, 8'h58, 8'h0F, 8'h3F, 8'hDD, 8'h61, 8'h04};
	// bits with a switchable pull-up
	localparam logic [7:0] PU_MASK [NPORT] = '{
		8'h00, 8'h00, 8'h78, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h04};

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [7:0] DATA_RST [NPORT] = '{
		8'h00, 8'hFF, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04};
	localparam logic [7:0] FC_RST [NPORT] = '{
		8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] DIR_RST = 8'h00;
	// pin bit positions used by the checks
	localparam int PIN_WAIT = PORT_P5 * PW + 5;
	localparam int PIN_IRQ0 = PORT_P5 * PW + 6;

endpackage : pfs_pkg

// ### logic/pfs_ctl_if.sv
// port function select: control bits of one port, register to mux
// assumes one instance per port inside the top module
`timescale 1ns/1ps
`default_nettype none

interface pfs_ctl_if;
	logic [7:0] data_latch;
	logic [7:0] direction_bits;
	logic [7:0] function_bits;
	modport regs (output data_latch, output direction_bits,
		output function_bits);
	modport mux (input data_latch, input direction_bits,
		input function_bits);
endinterface : pfs_ctl_if

`default_nettype wire

// ### logic/pfs_port_regs.sv
// port function select: latch, direction and function registers of a port
// assumes write strobes already decoded, one clock, async high reset
`timescale 1ns/1ps
`default_nettype none

module pfs_port_regs #(
	parameter int         W      = 8,
	parameter logic [7:0] CR_M   = 8'h00,
	parameter logic [7:0] FC_M   = 8'h00,
	parameter logic [7:0] FIX_M  = 8'h00,
	parameter logic [7:0] D_RST  = 8'h00,
	parameter logic [7:0] F_RST  = 8'h00
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// decoded writes
	input  wire logic [W-1:0] wr_data,
	input  wire logic         wr_latch,
	input  wire logic         wr_dir,
	input  wire logic         wr_func,
	// control bits out
	pfs_ctl_if.regs           ctl
);

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	if (W != 8) begin : g_bad_width
		$error("port width must be 8");
	end
	if ((CR_M & FIX_M) != 8'h00) begin : g_bad_mask
		$error("a bit cannot be both programmable and output only");
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [7:0] latch_reg;
	logic [7:0] dir_reg;
	logic [7:0] func_reg;

	// latch, direction and function bits; unbuilt direction and function bits stay zero
	// inputs after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			latch_reg <= D_RST;
			dir_reg   <= pfs_pkg::DIR_RST;
			func_reg  <= F_RST;
		end else begin
			if (wr_latch) latch_reg <= wr_data;
			if (wr_dir)   dir_reg   <= wr_data & CR_M;
			if (wr_func)  func_reg  <= wr_data & FC_M;
		end
	end

	assign ctl.data_latch     = latch_reg;
	assign ctl.direction_bits = dir_reg;
	assign ctl.function_bits  = func_reg;

endmodule : pfs_port_regs

`default_nettype wire

// ### logic/pfs_pin_cell.sv
// port function select: pad control decode for the eight bits of a port
// assumes registered control bits in; purely combinational
`timescale 1ns/1ps
`default_nettype none

module pfs_pin_cell #(
	parameter logic [7:0] CR_M  = 8'h00,
	parameter logic [7:0] FC_M  = 8'h00,
	parameter logic [7:0] FIX_M = 8'h00,
	parameter logic [7:0] PU_M  = 8'h00
) (
	// control bits in
	pfs_ctl_if.mux           ctl,
	// pad and peripheral side
	input  wire logic [7:0]  pad_in,
	input  wire logic [7:0]  func_out,
	input  wire logic [7:0]  func_drv,
	// decoded pad controls
	output logic      [7:0]  pad_out,
	output logic      [7:0]  pad_oe_n,
	output logic      [7:0]  pad_pu,
	output logic      [7:0]  func_in_en,
	output logic      [7:0]  rd_value
);

	// ****************************************************************
	// decode
	// ****************************************************************
	wire [7:0] impl  = CR_M | FIX_M;
	wire [7:0] dir   = (ctl.direction_bits & CR_M) | FIX_M;
	wire [7:0] fc    = ctl.function_bits & FC_M;
	wire [7:0] drive = dir & (~fc | func_drv);

	assign pad_out  = (fc & func_out) | (~fc & ctl.data_latch);
	assign pad_oe_n = ~(drive & impl);
	assign pad_pu   = PU_M & ~dir & ctl.data_latch;
	assign func_in_en = impl & ~dir & (fc | ~FC_M);
	// inputs read the pad, outputs read back the latch
	assign rd_value = impl & ((dir & ctl.data_latch) | (~dir & pad_in));

endmodule : pfs_pin_cell

`default_nettype wire

// ### logic/pfs_top.sv
// port function select: register slave, per-port registers and pad muxes
// assumes a plain one-cycle bus master and synchronous pad inputs
//
// Function
// - each pin: port bit or peripheral
// - input pin: latch switches pull-up
// - dir 1 drives latch, function routes peripheral
// - pull-ups only on ports 5, 8, strobe
// - wait pin: no select, input when dir 0
// - irq zero pin: input with select 1
// - reset makes programmable pins inputs
// - reset selects upper address function
`timescale 1ns/1ps
`default_nettype none

module pfs_top (
	// clock and reset
	input  wire logic                         CLK,
	input  wire logic                         RST,
	// register port
	input  wire logic [pfs_pkg::ADDR_W-1:0]   ADDR,
	input  wire logic [7:0]                   WDATA,
	input  wire logic                         WR,
	input  wire logic                         RD,
	output logic      [7:0]                   RDATA,
	// pad side
	input  wire logic [pfs_pkg::NPIN-1:0]     PAD_IN,
	output logic      [pfs_pkg::NPIN-1:0]     PAD_OUT,
	output logic      [pfs_pkg::NPIN-1:0]     PAD_OE_N,
	output logic      [pfs_pkg::NPIN-1:0]     PAD_PU,
	// peripheral side
	input  wire logic [pfs_pkg::NPIN-1:0]     FUNC_OUT,
	input  wire logic [pfs_pkg::NPIN-1:0]     FUNC_DRV,
	output logic      [pfs_pkg::NPIN-1:0]     FUNC_IN_EN
);

	localparam int NP = pfs_pkg::NPORT;
	localparam int NB = pfs_pkg::NPIN;

	// ****************************************************************
	// elaboration checks
	// ****************************************************************
	// pads are sliced in bytes and the map decodes five address bits
	if (NB != NP * 8) begin : g_bad_pins
		$error("pin count must be eight per port");
	end
	if (pfs_pkg::ADDR_W != 5) begin : g_bad_addr
		$error("register address must be five bits");
	end

	// ****************************************************************
	// bus decode
	// ****************************************************************
	wire [2:0] sel_port = ADDR[4:2];
	wire [1:0] sel_reg  = ADDR[1:0];
	wire       wr_latch = WR & (sel_reg == pfs_pkg::OFS_DATA);
	wire       wr_dir   = WR & (sel_reg == pfs_pkg::OFS_DIR);
	wire       wr_func  = WR & (sel_reg == pfs_pkg::OFS_FUNC);

	// per-port results
	logic [7:0]  rdv_arr [NP];
	logic [7:0]  dir_arr [NP];
	logic [7:0]  fc_arr  [NP];
	logic [NB-1:0] out_next;
	logic [NB-1:0] oe_n_next;
	logic [NB-1:0] pu_next;
	logic [NB-1:0] in_en_next;
	logic [NB-1:0] dir_all;
	logic [NB-1:0] fc_all;
	logic [NB-1:0] latch_all;
	logic [NB-1:0] pu_cap;
	logic [7:0]  latch_arr [NP];
	logic [NB-1:0] cr_cap;
	logic [NB-1:0] impl_all;

	// ****************************************************************
	// ports
	// ****************************************************************
	for (genvar p = 0; p < NP; p++) begin : g_port
		pfs_ctl_if ctl ();
		wire sel = (sel_port == 3'(p));

		pfs_port_regs #(
			.W     (8),
			.CR_M  (pfs_pkg::CR_MASK[p]),
			.FC_M  (pfs_pkg::FC_MASK[p]),
			.FIX_M (pfs_pkg::FIX_MASK[p]),
			.D_RST (pfs_pkg::DATA_RST[p]),
			.F_RST (pfs_pkg::FC_RST[p])
		) u_regs (
			.clk      (CLK),
			.rst      (RST),
			.wr_data  (WDATA),
			.wr_latch (wr_latch & sel),
			.wr_dir   (wr_dir & sel),
			.wr_func  (wr_func & sel),
			.ctl      (ctl.regs)
		);

		pfs_pin_cell #(
			.CR_M  (pfs_pkg::CR_MASK[p]),
			.FC_M  (pfs_pkg::FC_MASK[p]),
			.FIX_M (pfs_pkg::FIX_MASK[p]),
			.PU_M  (pfs_pkg::PU_MASK[p])
		) u_cell (
			.ctl        (ctl.mux),
			.pad_in     (PAD_IN[p*8 +: 8]),
			.func_out   (FUNC_OUT[p*8 +: 8]),
			.func_drv   (FUNC_DRV[p*8 +: 8]),
			.pad_out    (out_next[p*8 +: 8]),
			.pad_oe_n   (oe_n_next[p*8 +: 8]),
			.pad_pu     (pu_next[p*8 +: 8]),
			.func_in_en (in_en_next[p*8 +: 8]),
			.rd_value   (rdv_arr[p])
		);

		// readback and check views of the control bits
		assign dir_arr[p] = ctl.direction_bits;
		assign fc_arr[p]  = ctl.function_bits;
		assign dir_all[p*8 +: 8] = (ctl.direction_bits
			& pfs_pkg::CR_MASK[p]) | pfs_pkg::FIX_MASK[p];
		assign fc_all[p*8 +: 8]    = ctl.function_bits;
		assign latch_all[p*8 +: 8] = ctl.data_latch;
		assign pu_cap[p*8 +: 8]    = pfs_pkg::PU_MASK[p];
		assign latch_arr[p]        = ctl.data_latch;
		// capability views for the reset and idle checks
		assign cr_cap[p*8 +: 8]   = pfs_pkg::CR_MASK[p];
		assign impl_all[p*8 +: 8] = pfs_pkg::CR_MASK[p]
			| pfs_pkg::FIX_MASK[p];
	end

	// ****************************************************************
	// read mux
	// ****************************************************************
	wire [7:0] rd_mux =
		(sel_reg == pfs_pkg::OFS_DATA) ? rdv_arr[sel_port] :
		(sel_reg == pfs_pkg::OFS_DIR)  ? dir_arr[sel_port] :
		(sel_reg == pfs_pkg::OFS_FUNC) ? fc_arr[sel_port]  : 8'h00;

	// read data stand one cycle, zero otherwise and when unmapped
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) RDATA <= 8'h00;
		else     RDATA <= RD ? rd_mux : 8'h00;
	end

	// ****************************************************************
	// pad registers
	// ****************************************************************
	// decoded controls to pad flops
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			PAD_OUT    <= '0;
			PAD_OE_N   <= '1;
			PAD_PU     <= '0;
			FUNC_IN_EN <= '0;
		end else begin
			PAD_OUT    <= out_next;
			PAD_OE_N   <= oe_n_next;
			PAD_PU     <= pu_next;
			FUNC_IN_EN <= in_en_next;
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	// all checks on the one clock, quiet while reset stands
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	// write decodes watched by the checks
	wire wr_p1_func = wr_func && sel_port == 3'(pfs_pkg::PORT_P1);
	wire wr_p1_dir  = wr_dir && sel_port == 3'(pfs_pkg::PORT_P1);
	wire wr_pz_data = wr_latch && sel_port == 3'(pfs_pkg::PORT_PZ);
	wire wr_pz_any  = WR && sel_port == 3'(pfs_pkg::PORT_PZ);

	// slot decode and masks of the addressed port
	wire       map_hit     = sel_reg == pfs_pkg::OFS_DATA
		|| sel_reg == pfs_pkg::OFS_DIR || sel_reg == pfs_pkg::OFS_FUNC;
	wire       wr_unmapped = WR && !map_hit;
	wire       rd_dir      = RD && sel_reg == pfs_pkg::OFS_DIR;
	wire [7:0] sel_cr_mask = pfs_pkg::CR_MASK[sel_port];
	wire [7:0] sel_fc_mask = pfs_pkg::FC_MASK[sel_port];

	a_func_select: assert property (
		wr_p1_func |=> fc_all[7:0] == $past(WDATA))
		else $error("function bits not taken from write");

	a_pullup_follow: assert property (
		wr_pz_data && !dir_all[58] ##1 !wr_pz_any
		|=> PAD_PU[58] == $past(WDATA[2], 2))
		else $error("pull-up does not follow latch");

	a_port_drive: assert property (
		dir_all[0] && !fc_all[0] |=>
		!PAD_OE_N[0] && PAD_OUT[0] == $past(latch_all[0]))
		else $error("output pin not driving latch");

	a_func_route: assert property (
		dir_all[0] && fc_all[0] && FUNC_DRV[0] |=>
		!PAD_OE_N[0] && PAD_OUT[0] == $past(FUNC_OUT[0]))
		else $error("function output not routed");

	a_no_pullup: assert property (
		(PAD_PU & ~pu_cap) == '0)
		else $error("pull-up on a pin without one");

	// pad flops still hold reset values on the releasing edge
	a_wait_input: assert property (
		!RST && !dir_all[pfs_pkg::PIN_WAIT] |=>
		FUNC_IN_EN[pfs_pkg::PIN_WAIT] && PAD_OE_N[pfs_pkg::PIN_WAIT])
		else $error("wait pin not an input");

	a_wait_output: assert property (
		dir_all[pfs_pkg::PIN_WAIT] |=>
		!PAD_OE_N[pfs_pkg::PIN_WAIT] && !FUNC_IN_EN[pfs_pkg::PIN_WAIT])
		else $error("wait pin not an output");

	a_irq_input: assert property (
		!dir_all[pfs_pkg::PIN_IRQ0] |=>
		FUNC_IN_EN[pfs_pkg::PIN_IRQ0] == $past(fc_all[pfs_pkg::PIN_IRQ0]))
		else $error("irq zero input enable wrong");

	a_irq_output: assert property (
		dir_all[pfs_pkg::PIN_IRQ0] && !fc_all[pfs_pkg::PIN_IRQ0] |=>
		!PAD_OE_N[pfs_pkg::PIN_IRQ0] && !FUNC_IN_EN[pfs_pkg::PIN_IRQ0])
		else $error("irq zero pin not a plain output");

	a_reset_inputs: assert property (
		$past(RST) |-> (dir_all & cr_cap) == '0)
		else $error("pins not inputs after reset");

	a_addr_default: assert property (
		$past(RST) |-> fc_arr[pfs_pkg::PORT_P2] == 8'hFF)
		else $error("upper address function not set by reset");

	a_reg_apply: assert property (
		wr_p1_dir && fc_all[7:0] == 8'h00 |-> ##2
		PAD_OE_N[7:0] == ~$past(WDATA, 2))
		else $error("direction write not applied in two cycles");

	a_serial_drive: assert property (
		dir_all[40] && !fc_all[40] |=>
		!PAD_OE_N[40] && PAD_OUT[40] == $past(latch_all[40]))
		else $error("serial port pin not driving latch");

	// register writes land in the addressed port only
	// direction and function writes stored masked, latch writes whole
	a_latch_write: assert property (
		wr_latch |=> latch_arr[$past(sel_port)] == $past(WDATA))
		else $error("latch write not stored");

	a_dir_write: assert property (
		wr_dir |=> dir_arr[$past(sel_port)] == ($past(WDATA)
		& $past(sel_cr_mask)))
		else $error("direction write not stored masked");

	a_func_write: assert property (
		wr_func |=> fc_arr[$past(sel_port)] == ($past(WDATA)
		& $past(sel_fc_mask)))
		else $error("function write not stored masked");

	a_unmapped_quiet: assert property (
		wr_unmapped |=> $stable(latch_all) && $stable(dir_all)
		&& $stable(fc_all))
		else $error("unmapped write changed a register");

	// read port: data one cycle after the strobe, zero otherwise
	a_read_dir: assert property (
		rd_dir |=> RDATA == $past(dir_arr[sel_port]))
		else $error("direction readback wrong");

	a_read_idle: assert property (
		!RD |=> RDATA == 8'h00)
		else $error("read data not zero when idle");

	// pad controls that never combine
	a_pullup_input: assert property (
		(PAD_PU & ~PAD_OE_N) == '0)
		else $error("pull-up on a driven pin");

	a_in_en_quiet: assert property (
		(FUNC_IN_EN & ~PAD_OE_N) == '0)
		else $error("peripheral input on a driven pin");

	a_unbuilt_idle: assert property (
		((~PAD_OE_N | FUNC_IN_EN) & ~impl_all) == '0)
		else $error("unbuilt pin driven or read");

	a_addr_route: assert property (
		!RST && fc_all[15:8] == 8'hFF && FUNC_DRV[15:8] == 8'hFF
		|=> PAD_OE_N[15:8] == 8'h00
		&& PAD_OUT[15:8] == $past(FUNC_OUT[15:8]))
		else $error("upper address bus not routed");

	// main scenarios reached
	c_func_on: cover property (wr_p1_func ##1 fc_all[7:0] != 8'h00);
	c_pullup_on: cover property (!PAD_PU[58] ##1 PAD_PU[58]);
	c_irq_input: cover property (FUNC_IN_EN[pfs_pkg::PIN_IRQ0]);
	c_read_back: cover property (RD ##1 RDATA != 8'h00);
	c_wait_drive: cover property (!PAD_OE_N[pfs_pkg::PIN_WAIT]);

endmodule : pfs_top

`default_nettype wire

// ### tb/pfs_board_model.sv
// board model: pull-ups, external drivers and floating pins on every pad
// assumes pad controls from the pin mux and drive requests from the bench
`timescale 1ns/1ps
`default_nettype none

module pfs_board_model (
	// clock
	input  wire logic        clk,
	// pad controls from the block
	input  wire logic [63:0] pad_out,
	input  wire logic [63:0] pad_oe_n,
	input  wire logic [63:0] pad_pu,
	// board drivers set by the bench
	input  wire logic [63:0] ext_en,
	input  wire logic [63:0] ext_val,
	// resolved pin levels
	output logic      [63:0] pad_in
);
	// ****************************************************************
	// pin resolution
	// ****************************************************************
	logic [63:0] float_reg = 64'h5555_5555_5555_5555;

	// undriven pins without pull-up wander every cycle
	always_ff @(posedge clk) begin
		float_reg <= ~float_reg;
	end

	// block drive wins, then board driver, then pull-up, else floating
	assign pad_in = (~pad_oe_n & pad_out)
		| (pad_oe_n & ext_en & ext_val)
		| (pad_oe_n & ~ext_en & pad_pu)
		| (pad_oe_n & ~ext_en & ~pad_pu & float_reg);
endmodule : pfs_board_model

`default_nettype wire

// ### tb/port_function_select_bench.sv
// bench for the port function select block, one task per scenario
// assumes the board model on the pads, one clock of 200 MHz
`timescale 1ns/1ps
`default_nettype none

module port_function_select_bench;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic                        clk      = 1'b0;
	logic                        rst      = 1'b1;
	logic [pfs_pkg::ADDR_W-1:0]  addr     = 5'h00;
	logic [7:0]                  wdata    = 8'h00;
	logic                        wr       = 1'b0;
	logic                        rd       = 1'b0;
	logic [7:0]                  rdata;
	logic [63:0]                 pad_in, pad_out, pad_oe_n, pad_pu, fin_en;
	logic [63:0]                 func_out = 64'h0;
	logic [63:0]                 func_drv = '1;
	logic [63:0]                 ext_en   = 64'h0;
	logic [63:0]                 ext_val  = 64'h0;
	logic [7:0]                  got;
	int                          bad_count = 0;
	int                          cmp_count = 0;

	always #2.5 clk = ~clk;

	pfs_top dut_u (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata),
		.WR(wr), .RD(rd), .RDATA(rdata), .PAD_IN(pad_in),
		.PAD_OUT(pad_out), .PAD_OE_N(pad_oe_n), .PAD_PU(pad_pu),
		.FUNC_OUT(func_out), .FUNC_DRV(func_drv), .FUNC_IN_EN(fin_en));

	pfs_board_model board_u (.clk(clk), .pad_out(pad_out),
		.pad_oe_n(pad_oe_n), .pad_pu(pad_pu), .ext_en(ext_en),
		.ext_val(ext_val), .pad_in(pad_in));

	// ****************************************************************
	// helpers
	// ****************************************************************
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// one-cycle write, returns just after the strobe was taken
	task wr_reg(input logic [4:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask : wr_reg

	// one-cycle read, data taken in the cycle after the strobe
	task rd_reg(input logic [4:0] a, output logic [7:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask : rd_reg

	task step;
		@(posedge clk);
		#1;
	endtask : step

	task close_out;
		if (bad_count == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : close_out

	// ****************************************************************
	// scenarios
	// ****************************************************************
	task t_reset;
		rd_reg(5'h01, got); chk(got, 8'h00);
		rd_reg(5'h15, got); chk(got, 8'h00);
		rd_reg(5'h06, got); chk(got, 8'hFF);
		chk(pad_oe_n[7:0], 8'hFF);
		@(posedge clk);
		func_out <= 64'h0000_0000_0000_9600;
		step;
		step;
		chk(pad_out[15:8], 8'h96);
		chk(pad_oe_n[15:8], 8'h00);
	endtask : t_reset

	task t_output;
		wr_reg(5'h00, 8'hA5);
		wr_reg(5'h01, 8'hFF);
		chk(pad_oe_n[7:0], 8'hFF);
		step;
		chk(pad_oe_n[7:0], 8'h00);
		chk(pad_out[7:0], 8'hA5);
		rd_reg(5'h00, got); chk(got, 8'hA5);
		@(posedge clk);
		func_out <= 64'h0000_0000_0000_963C;
		func_drv <= 64'hFFFF_FFFF_FFFF_FF0F;
		wr_reg(5'h02, 8'hFF);
		step;
		chk(pad_out[7:0], 8'h3C);
		chk(pad_oe_n[7:0], 8'hF0);
	endtask : t_output

	task t_pullup;
		wr_reg(5'h14, 8'hFF); step; chk(pad_pu[47:40], 8'hFF);
		wr_reg(5'h14, 8'h0F); step; chk(pad_pu[47:40], 8'h0F);
		wr_reg(5'h15, 8'h03); step; chk(pad_pu[47:40], 8'h0C);
		wr_reg(5'h1C, 8'hFF);
		wr_reg(5'h01, 8'h00);
		step;
		chk(pad_pu[63:56], 8'h04);
		chk(pad_pu[7:0], 8'h00);
	endtask : t_pullup

	task t_wait_irq;
		@(posedge clk);
		ext_en[pfs_pkg::PIN_WAIT] <= 1'b1;
		wr_reg(5'h0A, 8'hFF);
		wr_reg(5'h08, 8'h20);
		step;
		chk(fin_en[pfs_pkg::PIN_WAIT], 1'b1);
		chk(pad_pu[pfs_pkg::PIN_WAIT], 1'b1);
		chk(fin_en[pfs_pkg::PIN_IRQ0], 1'b1);
		rd_reg(5'h08, got); chk(got & 8'h20, 8'h00);
		wr_reg(5'h08, 8'h60);
		wr_reg(5'h0A, 8'h18);
		wr_reg(5'h09, 8'h60);
		step;
		chk(pad_oe_n[pfs_pkg::PIN_WAIT], 1'b0);
		chk(fin_en[pfs_pkg::PIN_WAIT], 1'b0);
		chk(pad_oe_n[pfs_pkg::PIN_IRQ0], 1'b0);
		chk(pad_out[pfs_pkg::PIN_IRQ0], 1'b1);
	endtask : t_wait_irq

	task t_misc;
		@(posedge clk);
		ext_en[7:0] <= 8'hFF;
		ext_val[7:0] <= 8'h5A;
		wr_reg(5'h03, 8'hFF);
		rd_reg(5'h03, got); chk(got, 8'h00);
		rd_reg(5'h00, got); chk(got, 8'h5A);
		step;
		chk(rdata, 8'h00);
	endtask : t_misc

	// ****************************************************************
	// main sequence and watchdog
	// ****************************************************************
	initial begin
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_output;
		t_pullup;
		t_wait_irq;
		t_misc;
		close_out;
	end

	initial begin
		#20000;
		bad_count++;
		close_out;
	end
endmodule : port_function_select_bench

`default_nettype wire
